// file: hw/dpwm_pkg.sv
// Shared constants and types for the dual PWM timer with interlock.
// Assumes one peripheral clock and one system reset for both units.
package dpwm_pkg;
   localparam logic [15:0] TRIG_CTRL_ADDR = 16'hFF96;
   localparam logic [7:0] TRIG_CTRL_RST = 8'h00;
   localparam logic [7:0] TRIG_CTRL_MASK = 8'h03;
   localparam int TRIG_EN_BIT = 1;
   localparam int CAP_SEL_BIT = 0;
   localparam logic [7:0] IL_CTRL_RST = 8'h00;
   localparam int IL_MODE_LSB = 0;
   localparam int IL_SRC_BIT = 2;
   localparam int IL_HIZ_BIT = 3;
   localparam logic [1:0] IL_MODE_OFF = 2'h0;
   localparam logic [1:0] IL_MODE_RESET = 2'h1;
   localparam logic [1:0] IL_MODE_RESTART = 2'h2;
   localparam logic [1:0] IL_MODE_OUTRST = 2'h3;
   localparam logic [15:0] CNT_RST = 16'h0000;

   typedef enum logic [1:0] {ILS_NORMAL, ILS_HOLD, ILS_OUTRST} dpwm_il_e;

   // Per-unit settings; taken up at each period end while counting
   typedef struct packed {
      logic [15:0] period;
      logic [15:0] duty_a;
      logic [15:0] duty_b;
      logic compl;
      logic idle_a;
      logic idle_b;
      logic gate_en;
   } dpwm_cfg_s;

   // Byte or single-bit register access
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic bit_op;
      logic [2:0] bit_idx;
      logic [7:0] wdata;
   } dpwm_acc_s;
endpackage : dpwm_pkg

// file: hw/dpwm_timer.sv
// Two linked 16-bit PWM units, four outputs, A/D trigger, capture, interlock.
// Assumes all inputs synchronous to clk; peripheral bus gives one-cycle
// strobes; the A/D converter and comparators live outside.
`timescale 1ns/1ps
module dpwm_timer (
   input wire logic clk, // Peripheral clock
   input wire logic rst, // Async reset, active high
   input dpwm_pkg::dpwm_acc_s bus, // Peripheral register access
   output logic [7:0] rdata, // Read data, zero when unmapped
   input dpwm_pkg::dpwm_acc_s il_acc, // Interlock control access
   output logic [7:0] il_ctrl, // Interlock control contents
   input wire logic [1:0] start, // Start pulse per unit
   input wire logic [1:0] stop, // Stop pulse per unit
   input wire logic sync_en, // Link unit 1 to unit 0 start/clear
   input dpwm_pkg::dpwm_cfg_s cfg0, // Unit 0 settings
   input dpwm_pkg::dpwm_cfg_s cfg1, // Unit 1 settings
   input wire logic [15:0] cmp0_val, // Unit-1 channel-0 compare value
   input wire logic [2:0] cmp_out, // Comparator outputs
   input wire logic ext_irq_input0, // External interrupt input
   input wire logic gate_timer_output, // 8-bit timer output for gating
   input wire logic adc_run_enable, // A/D converter running
   output logic [3:0] pwm_out, // PWM levels, {u1b,u1a,u0b,u0a}
   output logic [3:0] pwm_oe_n, // Output enables, low drives
   output logic adc_sync_trig, // A/D sync trigger pulse
   output logic [15:0] unit1_cc_reg0, // Channel-0 compare/capture
   output logic [1:0] period_irq // Period-end pulse per unit
);
   import dpwm_pkg::*;

   function automatic logic [7:0] acc_write(input logic [7:0] old,
                                            input dpwm_acc_s a);
      logic [7:0] v;
      v = old;
      if (a.bit_op) begin
         v[a.bit_idx] = a.wdata[0];
      end else begin
         v = a.wdata;
      end
      return v;
   endfunction : acc_write

   function automatic logic pwm_lvl(input logic [15:0] c,
                                    input logic [15:0] duty,
                                    input logic idle);
      return (c < duty) ? ~idle : idle;
   endfunction : pwm_lvl

   logic [7:0] unit1_adc_trigger_ctrl, next_trig_ctrl;
   logic [7:0] next_il_ctrl;
   logic [7:0] next_rdata;
   logic src_q, next_src_q;
   logic hiz, next_hiz;
   dpwm_il_e il_st, next_il_st;
   logic [1:0] run, next_run;
   logic [15:0] cnt [2];
   logic [15:0] next_cnt [2];
   dpwm_cfg_s act [2];
   dpwm_cfg_s next_act [2];
   logic [15:0] next_cc;
   logic next_trig;
   logic [1:0] next_irq;
   logic [3:0] next_out, next_oe_n;

   logic src, edge_det, hold, restart;
   logic [1:0] mode, wrap, start_req, stop_req;
   dpwm_cfg_s cfg [2];

   always_comb begin
      logic a_lvl;
      logic b_lvl;
      logic quiet;
      a_lvl = 1'b0;
      b_lvl = 1'b0;
      quiet = 1'b0;
      cfg[0] = cfg0;
      cfg[1] = cfg1;
      mode = il_ctrl[IL_MODE_LSB +: 2];
      src = il_ctrl[IL_SRC_BIT] ? ext_irq_input0 : cmp_out[2];
      edge_det = src & ~src_q;
      hold = (mode == IL_MODE_RESET) && src;
      restart = (mode == IL_MODE_RESTART) && edge_det;
      // Unit 0 start/stop drags unit 1 along when linked
      start_req = {start[1] | (sync_en & start[0]), start[0]};
      stop_req = {stop[1] | (sync_en & stop[0]), stop[0]};
      wrap[0] = run[0] && (cnt[0] == act[0].period);
      wrap[1] = run[1] && ((cnt[1] == act[1].period) ||
                (sync_en && wrap[0]));

      next_trig_ctrl = unit1_adc_trigger_ctrl;
      if (bus.wr && bus.addr == TRIG_CTRL_ADDR) begin
         next_trig_ctrl = acc_write(unit1_adc_trigger_ctrl, bus) &
                          TRIG_CTRL_MASK;
      end
      next_rdata = 8'h00;
      if (bus.rd && bus.addr == TRIG_CTRL_ADDR) begin
         next_rdata = unit1_adc_trigger_ctrl;
      end
      next_il_ctrl = il_ctrl;
      if (il_acc.wr) begin
         next_il_ctrl = acc_write(il_ctrl, il_acc);
      end

      next_src_q = src;
      // Clear from disabling the feature wins; a set needs the feature enabled
      next_hiz = hiz & il_ctrl[IL_HIZ_BIT];
      if (il_ctrl[IL_HIZ_BIT] && edge_det) begin
         next_hiz = 1'b1;
      end

      next_il_st = il_st;
      unique case (il_st)
         ILS_NORMAL: begin
            if (hold) begin
               next_il_st = ILS_HOLD;
            end else if (mode == IL_MODE_OUTRST && edge_det) begin
               next_il_st = ILS_OUTRST;
            end
         end
         ILS_HOLD: begin
            if (!hold) begin
               next_il_st = ILS_NORMAL;
            end
         end
         ILS_OUTRST: begin
            if (wrap[0] || mode != IL_MODE_OUTRST) begin
               next_il_st = ILS_NORMAL;
            end
         end
      endcase

      // Both units share clk and rst, so linked edges line up exactly
      for (int i = 0; i < 2; i++) begin
         next_run[i] = (run[i] & ~stop_req[i]) | start_req[i];
         next_act[i] = act[i];
         if (!run[i] || wrap[i]) begin
            next_cnt[i] = CNT_RST;
            next_act[i] = cfg[i];
         end else if (hold || restart) begin
            next_cnt[i] = CNT_RST;
         end else begin
            next_cnt[i] = cnt[i] + 16'h0001;
         end
         next_irq[i] = wrap[i];
         a_lvl = pwm_lvl(cnt[i], act[i].duty_a, act[i].idle_a);
         b_lvl = act[i].compl ? ~a_lvl :
                 pwm_lvl(cnt[i], act[i].duty_b, act[i].idle_b);
         quiet = !run[i] || hold || il_st == ILS_OUTRST ||
                 (act[i].gate_en && !gate_timer_output);
         next_out[2*i] = quiet ? act[i].idle_a : a_lvl;
         next_out[2*i+1] = quiet ? act[i].idle_b : b_lvl;
      end
      next_oe_n = {4{next_hiz}};

      // Capture only on an event; compare value follows software otherwise
      next_cc = cmp0_val;
      if (unit1_adc_trigger_ctrl[CAP_SEL_BIT]) begin
         next_cc = edge_det ? cnt[1] : unit1_cc_reg0;
      end
      // Trigger path gates timer state with adc_run_enable; no trigger while the converter is stopped
      next_trig = unit1_adc_trigger_ctrl[TRIG_EN_BIT] && run[1] &&
                  cnt[1] == unit1_cc_reg0 &&
                  adc_run_enable;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unit1_adc_trigger_ctrl <= TRIG_CTRL_RST;
         il_ctrl <= IL_CTRL_RST;
         rdata <= 8'h00;
         src_q <= 1'b0;
         hiz <= 1'b0;
         il_st <= ILS_NORMAL;
         run <= 2'h0;
         for (int i = 0; i < 2; i++) begin
            cnt[i] <= CNT_RST;
            act[i] <= '0;
         end
         unit1_cc_reg0 <= CNT_RST;
         adc_sync_trig <= 1'b0;
         period_irq <= 2'h0;
         pwm_out <= 4'h0;
         pwm_oe_n <= 4'h0;
      end else begin
         unit1_adc_trigger_ctrl <= next_trig_ctrl;
         il_ctrl <= next_il_ctrl;
         rdata <= next_rdata;
         src_q <= next_src_q;
         hiz <= next_hiz;
         il_st <= next_il_st;
         run <= next_run;
         for (int i = 0; i < 2; i++) begin
            cnt[i] <= next_cnt[i];
            act[i] <= next_act[i];
         end
         unit1_cc_reg0 <= next_cc;
         adc_sync_trig <= next_trig;
         period_irq <= next_irq;
         pwm_out <= next_out;
         pwm_oe_n <= next_oe_n;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_trig_needs_en: assert property (
      adc_sync_trig |-> $past(unit1_adc_trigger_ctrl[TRIG_EN_BIT]))
      else $error("trigger without enable");
   a_trig_on_match: assert property (
      (unit1_adc_trigger_ctrl[TRIG_EN_BIT] && run[1] && adc_run_enable &&
       cnt[1] == unit1_cc_reg0) |=> adc_sync_trig)
      else $error("missed trigger on match");
   a_adc_stopped: assert property (
      !adc_run_enable |=> !adc_sync_trig)
      else $error("trigger while converter stopped");
   a_ctrl_reserved: assert property (
      unit1_adc_trigger_ctrl[7:2] == 6'h00)
      else $error("reserved trigger control bits set");
   a_hold_clears: assert property (
      (mode == IL_MODE_RESET && src) |=> (cnt[0] == CNT_RST &&
       cnt[1] == CNT_RST && pwm_out == $past({act[1].idle_b, act[1].idle_a,
       act[0].idle_b, act[0].idle_a})))
      else $error("hold did not clear counters");
   a_restart_edge: assert property (
      (restart && run[0] && !wrap[0] && !stop[0]) |=> cnt[0] == CNT_RST)
      else $error("restart edge ignored");
   a_outrst_idle: assert property (
      (il_st == ILS_OUTRST) |=> pwm_out == $past({act[1].idle_b,
       act[1].idle_a, act[0].idle_b, act[0].idle_a}))
      else $error("outputs not reset");
   a_hiz_edge: assert property (
      (il_ctrl[IL_HIZ_BIT] && edge_det) |=> pwm_oe_n == 4'hF [*2])
      else $error("outputs not released to high impedance");
   a_capture_cnt: assert property (
      (unit1_adc_trigger_ctrl[CAP_SEL_BIT] && edge_det) |=>
      unit1_cc_reg0 == $past(cnt[1]))
      else $error("capture lost");
   a_sync_start: assert property (
      (sync_en && start[0]) |=> run == 2'h3)
      else $error("linked start failed");
   a_sync_clear: assert property (
      (sync_en && wrap[0] && run[1]) |=> cnt[1] == CNT_RST)
      else $error("linked clear failed");

   // Register side
   a_compare_load: assert property (
      !unit1_adc_trigger_ctrl[CAP_SEL_BIT] |=>
      unit1_cc_reg0 == $past(cmp0_val))
      else $error("compare value not loaded");
   a_capture_keep: assert property (
      (unit1_adc_trigger_ctrl[CAP_SEL_BIT] && !edge_det) |=>
      $stable(unit1_cc_reg0))
      else $error("capture register changed without event");
   a_il_write: assert property (
      (il_acc.wr && !il_acc.bit_op) |=> il_ctrl == $past(il_acc.wdata))
      else $error("interlock control write lost");
   a_trig_write: assert property (
      (bus.wr && bus.addr == TRIG_CTRL_ADDR && !bus.bit_op) |=>
      unit1_adc_trigger_ctrl == ($past(bus.wdata) & TRIG_CTRL_MASK))
      else $error("trigger control write lost");
   a_rdata_unmapped: assert property (
      !(bus.rd && bus.addr == TRIG_CTRL_ADDR) |=> rdata == 8'h00)
      else $error("read data without a mapped read");

   // Output side; idle levels come from the settings in use
   a_gate_idle: assert property (
      (act[0].gate_en && !gate_timer_output) |=>
      pwm_out[1:0] == $past({act[0].idle_b, act[0].idle_a}))
      else $error("gated outputs not idle");
   a_stop_idle: assert property (
      !run[0] |=> pwm_out[1:0] == $past({act[0].idle_b, act[0].idle_a}))
      else $error("stopped outputs not idle");
   a_period_end: assert property (
      wrap[0] |=> period_irq[0] && cnt[0] == CNT_RST)
      else $error("period end not flagged");
   a_hiz_off: assert property (
      !il_ctrl[IL_HIZ_BIT] |=> pwm_oe_n == 4'h0)
      else $error("outputs released while disabled");
endmodule : dpwm_timer

// file: tb/dpwm_far_side.sv
// Far side of the timer: bridge gate drivers and the A/D converter.
// Assumes the timer outputs are registered on clk.
`timescale 1ns/1ps
module dpwm_far_side (
   input wire logic clk, // Peripheral clock
   input wire logic adc_run_enable, // Converter running
   input wire logic adc_sync_trig, // Trigger from the timer
   input wire logic [3:0] pwm_out, // Timer levels
   input wire logic [3:0] pwm_oe_n, // Low while timer drives
   output int conv_cnt, // Conversions started
   output tri0 [3:0] gate_pin // Driver inputs, pulled down
);
   // Released pins fall to the pull-down, never keep the old level
   for (genvar i = 0; i < 4; i++) begin : g_pin
      assign gate_pin[i] = pwm_oe_n[i] ? 1'bz : pwm_out[i];
   end
   initial conv_cnt = 0;
   always @(posedge clk) begin
      if (adc_sync_trig && adc_run_enable) begin
         conv_cnt <= conv_cnt + 1;
      end
   end
endmodule : dpwm_far_side

// file: tb/dual_pwm_timer_with_interlock_test.sv
// Bench for the dual PWM timer: registers, PWM, trigger, capture, interlock.
// Assumes the far-side model in dpwm_far_side.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module dual_pwm_timer_with_interlock_test;
   import dpwm_pkg::*;
   logic clk, rst, sync_en, ext_irq_input0, gate_timer_output;
   logic adc_run_enable, adc_sync_trig;
   logic [1:0] start, stop, period_irq;
   dpwm_acc_s bus, il_acc;
   dpwm_cfg_s cfg0, cfg1;
   logic [7:0] rdata, il_ctrl;
   logic [15:0] cmp0_val, unit1_cc_reg0;
   logic [2:0] cmp_out;
   logic [3:0] pwm_out, pwm_oe_n;
   wire [3:0] gate_pin;
   int mismatches, n_checks, seed, conv_cnt, hits, i;
   dpwm_timer dut (.clk, .rst, .bus, .rdata, .il_acc, .il_ctrl, .start,
      .stop, .sync_en, .cfg0, .cfg1, .cmp0_val, .cmp_out, .ext_irq_input0,
      .gate_timer_output, .adc_run_enable, .pwm_out, .pwm_oe_n,
      .adc_sync_trig, .unit1_cc_reg0, .period_irq);
   dpwm_far_side far (.clk, .adc_run_enable, .adc_sync_trig, .pwm_out,
      .pwm_oe_n, .conv_cnt, .gate_pin);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task tick;
      @(posedge clk);
      #1;
   endtask : tick
   task wr(input logic [15:0] a, input logic [7:0] d);
      bus.addr = a;
      bus.wdata = d;
      bus.wr = 1'b1;
      tick;
      bus.wr = 1'b0;
      tick;
   endtask : wr
   task rd(input logic [15:0] a, input logic [7:0] e);
      bus.addr = a;
      bus.rd = 1'b1;
      tick;
      `CHK(rdata, e)
      bus.rd = 1'b0;
      tick;
   endtask : rd
   task ilw(input logic [7:0] d);
      il_acc.wdata = d;
      il_acc.wr = 1'b1;
      tick;
      il_acc.wr = 1'b0;
      tick;
   endtask : ilw
   // Stopped first: trigger control may not change while counting
   task trig_cfg(input logic [7:0] d);
      stop = 2'b11;
      tick;
      stop = 2'b00;
      wr(TRIG_CTRL_ADDR, d);
      start = 2'b11;
      tick;
      start = 2'b00;
      tick;
   endtask : trig_cfg
   // One full period seen from any phase holds exactly duty active cycles
   task meas;
      hits = 0;
      i = 0;
      repeat (cfg0.period + 1) begin
         tick;
         hits += (pwm_out[0] !== cfg0.idle_a);
         i += period_irq[0];
         `CHK(pwm_out[1], ~pwm_out[0])
         `CHK(pwm_out[2], pwm_out[0])
         `CHK(period_irq[1], period_irq[0])
      end
      `CHK(i, 1)
   endtask : meas
   task wait_lvl(input logic l);
      i = 0;
      while (pwm_out[0] !== l && i < 100) begin
         tick;
         i++;
      end
   endtask : wait_lvl
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      stop_test;
   end
   initial begin
      seed = 32'h1fc9;
      {rst, sync_en, ext_irq_input0, gate_timer_output} = 4'hC;
      {adc_run_enable, start, stop, cmp_out} = 8'h00;
      {bus, il_acc, cfg0} = '0;
      cmp0_val = 16'h0003;
      cfg0.period = 16'h0008;
      cfg0.compl = 1'b1;
      cfg1 = cfg0;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      rd(TRIG_CTRL_ADDR, TRIG_CTRL_RST);
      rd(16'hFF90, 8'h00);
      `CHK(il_ctrl, IL_CTRL_RST)
      wr(TRIG_CTRL_ADDR, 8'hFF);
      rd(TRIG_CTRL_ADDR, TRIG_CTRL_MASK);
      bus.bit_op = 1'b1;
      bus.bit_idx = 3'h7;
      wr(TRIG_CTRL_ADDR, 8'h01);
      bus.bit_idx = 3'h0;
      wr(TRIG_CTRL_ADDR, 8'h00);
      bus.bit_op = 1'b0;
      rd(TRIG_CTRL_ADDR, 8'h02);
      il_acc.bit_op = 1'b1;
      il_acc.bit_idx = 3'h6;
      ilw(8'h01);
      `CHK(il_ctrl, 8'h40)
      il_acc.bit_op = 1'b0;
      ilw(8'h04);
      // Gating in the last two rounds, closed then open
      for (int k = 0; k < 6; k++) begin
         cfg0.period = 16'h8 + 16'($unsigned($random(seed)) % 16);
         cfg0.duty_a = 16'(1 + $unsigned($random(seed)) % cfg0.period);
         cfg0.idle_a = 1'($random(seed));
         cfg0.idle_b = ~cfg0.idle_a;
         cfg0.gate_en = k > 3;
         gate_timer_output = k == 5;
         cfg1 = cfg0;
         if (k == 0) begin
            start = 2'b01;
            tick;
            start = 2'b00;
         end
         // Old period may run up to 24 cycles before the new one is taken
         repeat (cfg0.period + 30) tick;
         meas;
         `CHK(hits, k == 4 ? 0 : int'(cfg0.duty_a))
      end
      cfg0.gate_en = 1'b0;
      cfg0.duty_a = 16'h0006;
      cfg1 = cfg0;
      for (int k = 0; k < 3; k++) begin
         adc_run_enable = k != 1;
         trig_cfg(k == 0 ? 8'h00 : 8'h02);
         i = conv_cnt;
         hits = 0;
         repeat (3 * (cfg0.period + 1)) begin
            tick;
            hits += adc_sync_trig;
         end
         `CHK(hits, k == 2 ? 3 : 0)
         `CHK(conv_cnt - i, k == 2 ? 3 : 0)
      end
      trig_cfg(8'h01);
      repeat (3) tick;
      ext_irq_input0 = 1'b1;
      tick;
      `CHK(unit1_cc_reg0, 16'h0004)
      ext_irq_input0 = 1'b0;
      ilw(8'h05);
      ext_irq_input0 = 1'b1;
      repeat (cfg0.period + 2) tick;
      `CHK(pwm_out[0], cfg0.idle_a)
      ext_irq_input0 = 1'b0;
      repeat (3) tick;
      meas;
      `CHK(hits, 6)
      ilw(8'h06);
      wait_lvl(cfg0.idle_a);
      ext_irq_input0 = 1'b1;
      tick;
      tick;
      `CHK(pwm_out[0], ~cfg0.idle_a)
      ext_irq_input0 = 1'b0;
      ilw(8'h07);
      wait_lvl(~cfg0.idle_a);
      ext_irq_input0 = 1'b1;
      tick;
      tick;
      ext_irq_input0 = 1'b0;
      hits = 0;
      for (i = 0; i < 100 && !period_irq[0]; i++) begin
         hits += (pwm_out[0] !== cfg0.idle_a);
         tick;
      end
      `CHK(hits, 0)
      repeat (cfg0.period + 1) tick;
      meas;
      `CHK(hits, 6)
      ilw(8'h0C);
      ext_irq_input0 = 1'b1;
      tick;
      tick;
      `CHK(pwm_oe_n, 4'hF)
      `CHK(gate_pin, 4'h0)
      ext_irq_input0 = 1'b0;
      ilw(8'h04);
      `CHK(pwm_oe_n, 4'h0)
      // Same release from the comparator side of the source select
      ilw(8'h08);
      cmp_out = 3'h4;
      tick;
      tick;
      `CHK(pwm_oe_n, 4'hF)
      cmp_out = 3'h0;
      ilw(8'h00);
      `CHK(pwm_oe_n, 4'h0)
      stop_test;
   end
endmodule : dual_pwm_timer_with_interlock_test
